// File: cie_clear_exec.sv
// Clear-type instruction decode and execute with a Wishbone register port
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps

// Functional notes
// - Clear-file takes a 7-bit operand addressing file registers 0 to 127.
// - Clear-file writes zero to the register and sets zero; other flags unchanged.
// - Clear-file pattern is 00 0001 1fff ffff, low seven bits address.
// - Clear-file decodes Q1, reads Q2, processes Q3, writes register Q4.
// - Clear-accumulator loads zero into the accumulator and sets zero.
// - Clear-accumulator pattern is 00 0001 0xxx xxxx.
// - Clear-accumulator: no read in Q2, process Q3, write accumulator Q4.
// - Clear-watchdog resets the watchdog counter to zero.
// - Clear-watchdog also resets the watchdog prescaler to zero.
// - Clear-watchdog sets timeout and powerdown flags; no other status bits.
// - Clear-watchdog pattern is exactly 00 0000 0110 0100.
// - Clear-watchdog decodes Q1, idles Q2, processes Q3, clears counter Q4.
// - Each clear is one word and finishes within one instruction cycle.
module cie_clear_exec
  import cie_pkg::*;
#(
  parameter int FILE_DEPTH = 128,
  parameter int WDCNT_W    = 16
) (
  // System
  input  wire logic        clock,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Watchdog side
  output logic             watchdog_clear,
  output logic             prescaler_clear,
  // Core status view
  output logic             zero_flag,
  output logic             timeout_flag,
  output logic             powerdown_flag,
  output logic             busy
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (FILE_DEPTH < 1 || FILE_DEPTH > 128) begin : g_chk_depth
    $error("FILE_DEPTH must lie between 1 and 128");
  end
  if (WDCNT_W < 1 || WDCNT_W > 32) begin : g_chk_wdcnt
    $error("WDCNT_W must lie between 1 and 32");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    cie_phase_t                    phase;
    cie_kind_t                     kind;
    logic [13:0]                   opcode;
    logic [7:0]                    accum;
    logic                          zero;
    logic                          timeout;
    logic                          powerdown;
    logic                          unknown;
    logic [6:0]                    fsel;
    logic [7:0]                    fread;
    logic [7:0]                    result;
    logic [FILE_DEPTH-1:0][7:0]    files;
    logic                          wdog_clr;
    logic [WDCNT_W-1:0]            wdcnt;
    logic                          ack;
    logic [31:0]                   dat;
  } cie_state_t;

  cie_state_t st;
  cie_state_t next_st;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Classify a 14-bit opcode; the low seven bits of clear-accumulator are ignored
  function automatic cie_kind_t decode_op(input logic [13:0] op);
    if (op[13:7] == CIE_OPC_FILE_HI) begin
      decode_op = CIE_K_FILE;
    end else if (op[13:7] == CIE_OPC_ACC_HI) begin
      decode_op = CIE_K_ACC;
    end else if (op == CIE_OPC_WDOG) begin
      decode_op = CIE_K_WDOG;
    end else begin
      decode_op = CIE_K_NONE;
    end
  endfunction : decode_op

  // Read a file register; addresses beyond the fitted depth read as zero
  function automatic logic [7:0] file_rd(input logic [FILE_DEPTH-1:0][7:0] f,
                                         input logic [6:0] a);
    file_rd = 8'h00;
    if (32'(a) < FILE_DEPTH) begin
      file_rd = f[a];
    end
  endfunction : file_rd

  // Apply byte-lane enables to an 8-bit register held in lane 0
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [3:0] sel,
                                       input logic [31:0] d);
    lane0 = sel[0] ? d[7:0] : old;
  endfunction : lane0

  // ----------------------------------------------------------------
  // Bus qualifiers
  // ----------------------------------------------------------------
  logic bus_req;
  logic bus_wr;
  logic idle;

  // Request seen, and write committed at the edge where ack is sampled
  assign bus_req = cyc_i & stb_i & ~st.ack;
  assign bus_wr  = cyc_i & stb_i & we_i & st.ack;
  assign idle    = (st.phase == CIE_IDLE);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Sequences quarter phases and serves the register bus
  always_comb begin
    next_st         = st;
    next_st.wdog_clr = 1'b0;
    next_st.ack     = bus_req;

    // Quarter-phase sequencer; one instruction cycle is four clocks
    case (st.phase)
      CIE_IDLE: begin
        next_st.phase = CIE_IDLE;
      end
      CIE_Q1: begin
        // Decode the single opcode word
        next_st.kind    = decode_op(st.opcode);
        next_st.unknown = (decode_op(st.opcode) == CIE_K_NONE);
        next_st.phase   = CIE_Q2;
      end
      CIE_Q2: begin
        // Only clear-file reads its operand; the others idle here
        if (st.kind == CIE_K_FILE) begin
          next_st.fread = file_rd(st.files, st.opcode[6:0]);
        end
        next_st.phase = CIE_Q3;
      end
      CIE_Q3: begin
        // Processing: every clear produces a zero result
        next_st.result = 8'h00;
        next_st.phase  = CIE_Q4;
      end
      CIE_Q4: begin
        // Write-back ends the instruction within this cycle
        case (st.kind)
          CIE_K_FILE: begin
            if (32'(st.opcode[6:0]) < FILE_DEPTH) begin
              next_st.files[st.opcode[6:0]] = st.result;
            end
            next_st.zero = 1'b1;
          end
          CIE_K_ACC: begin
            next_st.accum = st.result;
            next_st.zero  = 1'b1;
          end
          CIE_K_WDOG: begin
            next_st.wdog_clr  = 1'b1;
            next_st.timeout   = 1'b1;
            next_st.powerdown = 1'b1;
            next_st.wdcnt     = st.wdcnt + WDCNT_W'(1);
          end
          default: begin
            next_st.kind = CIE_K_NONE;
          end
        endcase
        next_st.phase = CIE_IDLE;
      end
      default: begin
        next_st.phase = CIE_IDLE;
      end
    endcase

    // Register reads: data loads with the rising ack
    if (bus_req && !we_i) begin
      case (adr_i)
        CIE_ADDR_INSTR:  next_st.dat = {18'h00000, st.opcode};
        CIE_ADDR_STATUS: begin
          next_st.dat                 = 32'h00000000;
          next_st.dat[CIE_ST_ZERO]    = st.zero;
          next_st.dat[CIE_ST_TIMEOUT] = st.timeout;
          next_st.dat[CIE_ST_PWRDOWN] = st.powerdown;
          next_st.dat[CIE_ST_BUSY]    = ~idle;
          next_st.dat[CIE_ST_UNKNOWN] = st.unknown;
        end
        CIE_ADDR_ACCUM:  next_st.dat = {24'h000000, st.accum};
        CIE_ADDR_FSEL:   next_st.dat = {25'h0000000, st.fsel};
        CIE_ADDR_FDATA:  next_st.dat = {24'h000000, file_rd(st.files, st.fsel)};
        CIE_ADDR_WDCNT:  next_st.dat = 32'(st.wdcnt);
        default:         next_st.dat = 32'h00000000;
      endcase
    end

    // Register writes; those that touch core state are refused while busy
    if (bus_wr) begin
      case (adr_i)
        CIE_ADDR_INSTR: begin
          if (idle && sel_i[1:0] == 2'h3) begin
            next_st.opcode = dat_i[13:0];
            next_st.phase  = CIE_Q1;
          end
        end
        CIE_ADDR_STATUS: begin
          if (idle && sel_i[0]) begin
            next_st.zero      = dat_i[CIE_ST_ZERO];
            next_st.timeout   = dat_i[CIE_ST_TIMEOUT];
            next_st.powerdown = dat_i[CIE_ST_PWRDOWN];
            next_st.unknown   = dat_i[CIE_ST_UNKNOWN];
          end
        end
        CIE_ADDR_ACCUM: begin
          if (idle) begin
            next_st.accum = lane0(st.accum, sel_i, dat_i);
          end
        end
        CIE_ADDR_FSEL: begin
          if (sel_i[0]) begin
            next_st.fsel = dat_i[6:0];
          end
        end
        CIE_ADDR_FDATA: begin
          if (idle && sel_i[0] && 32'(st.fsel) < FILE_DEPTH) begin
            next_st.files[st.fsel] = dat_i[7:0];
          end
        end
        default: begin
          next_st.fsel = st.fsel;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Asynchronous reset to constants only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st           <= '0;
      st.phase     <= CIE_IDLE;
      st.kind      <= CIE_K_NONE;
      st.opcode    <= CIE_RST_OPCODE;
      st.accum     <= CIE_RST_ACCUM;
      st.zero      <= CIE_RST_FLAG;
      st.timeout   <= CIE_RST_TOPD;
      st.powerdown <= CIE_RST_TOPD;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // All outputs come straight from the state register, except busy, which is decoded from the phase
  assign dat_o           = st.dat;
  assign ack_o           = st.ack;
  assign watchdog_clear  = st.wdog_clr;
  assign prescaler_clear = st.wdog_clr;
  assign zero_flag       = st.zero;
  assign timeout_flag    = st.timeout;
  assign powerdown_flag  = st.powerdown;
  assign busy            = ~idle;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_phase_walk: assert property (@(posedge clock) disable iff (rst)
    (st.phase == CIE_Q1) |=> (st.phase == CIE_Q2) ##1 (st.phase == CIE_Q3)
                             ##1 (st.phase == CIE_Q4) ##1 (st.phase == CIE_IDLE))
    else $error("Instruction did not complete in four quarter phases");

  a_decode_file: assert property (@(posedge clock) disable iff (rst)
    (st.phase == CIE_Q1 && st.opcode[13:7] == 7'h03) |=> (st.kind == CIE_K_FILE))
    else $error("Clear-file pattern not decoded");

  a_decode_acc: assert property (@(posedge clock) disable iff (rst)
    (st.phase == CIE_Q1 && st.opcode[13:7] == 7'h02) |=> (st.kind == CIE_K_ACC))
    else $error("Clear-accumulator pattern not decoded");

  a_decode_wdog: assert property (@(posedge clock) disable iff (rst)
    (st.phase == CIE_Q1) |=> ((st.kind == CIE_K_WDOG) == ($past(st.opcode) == CIE_OPC_WDOG)))
    else $error("Clear-watchdog decode mismatch");

  a_file_cleared: assert property (@(posedge clock) disable iff (rst)
    (st.phase == CIE_Q4 && st.kind == CIE_K_FILE && st.opcode[6:0] == st.fsel)
    |=> (file_rd(st.files, st.fsel) == 8'h00) && st.zero
        && $stable(st.timeout) && $stable(st.powerdown))
    else $error("Clear-file did not zero the register or disturbed flags");

  a_file_read_q2: assert property (@(posedge clock) disable iff (rst)
    (st.phase == CIE_Q2 && st.kind == CIE_K_FILE)
    |=> (st.fread == file_rd(st.files, st.opcode[6:0])))
    else $error("Clear-file operand not read in second quarter");

  a_acc_cleared: assert property (@(posedge clock) disable iff (rst)
    (st.phase == CIE_Q1 && st.opcode[13:7] == 7'h02)
    |-> ##4 (st.accum == 8'h00) && st.zero && (st.phase == CIE_IDLE))
    else $error("Clear-accumulator did not zero the accumulator in one cycle");

  a_wdog_pulse: assert property (@(posedge clock) disable iff (rst)
    (st.phase == CIE_Q4 && st.kind == CIE_K_WDOG)
    |=> watchdog_clear && prescaler_clear ##1 !watchdog_clear)
    else $error("Watchdog clear not a single pulse after fourth quarter");

  a_wdog_flags: assert property (@(posedge clock) disable iff (rst)
    watchdog_clear |-> timeout_flag && powerdown_flag && $stable(zero_flag))
    else $error("Clear-watchdog flags wrong");

  a_wdog_cause: assert property (@(posedge clock) disable iff (rst)
    watchdog_clear |-> ($past(st.phase) == CIE_Q4) && ($past(st.opcode) == CIE_OPC_WDOG))
    else $error("Watchdog clear without clear-watchdog instruction");

  a_acc_noread: assert property (@(posedge clock) disable iff (rst)
    (st.phase == CIE_Q2 && st.kind != CIE_K_FILE) |=> $stable(st.fread))
    else $error("Operand read by an instruction that reads no register");

  a_file_any: assert property (@(posedge clock) disable iff (rst)
    (st.phase == CIE_Q4 && st.kind == CIE_K_FILE)
    |=> (file_rd(st.files, st.opcode[6:0]) == 8'h00))
    else $error("Addressed file register not cleared");

  a_busy_span: assert property (@(posedge clock) disable iff (rst)
    $rose(busy) |-> busy[*4] ##1 !busy)
    else $error("Instruction did not occupy exactly one cycle");

  a_file_flags: assert property (@(posedge clock) disable iff (rst)
    (st.phase == CIE_Q4 && st.kind == CIE_K_FILE)
    |=> st.zero && $stable(st.timeout) && $stable(st.powerdown))
    else $error("Clear-file flags wrong");

endmodule : cie_clear_exec

// File: cie_pkg.sv
// Package for the clear-instruction execute block: register map, encodings, phases
package cie_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the Wishbone bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] CIE_ADDR_INSTR  = 8'h00; // Issue opcode / read last opcode
  localparam logic [7:0] CIE_ADDR_STATUS = 8'h04; // Flags and busy
  localparam logic [7:0] CIE_ADDR_ACCUM  = 8'h08; // Working accumulator
  localparam logic [7:0] CIE_ADDR_FSEL   = 8'h0C; // File register index for bus access
  localparam logic [7:0] CIE_ADDR_FDATA  = 8'h10; // File register data at index
  localparam logic [7:0] CIE_ADDR_WDCNT  = 8'h14; // Count of watchdog clears

  // ----------------------------------------------------------------
  // Status register field positions
  // ----------------------------------------------------------------
  localparam int CIE_ST_ZERO    = 0;
  localparam int CIE_ST_TIMEOUT = 1;
  localparam int CIE_ST_PWRDOWN = 2;
  localparam int CIE_ST_BUSY    = 3;
  localparam int CIE_ST_UNKNOWN = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CIE_RST_ACCUM  = 8'h00;
  localparam logic [13:0] CIE_RST_OPCODE = 14'h0000;
  localparam logic        CIE_RST_FLAG   = 1'b0;
  localparam logic        CIE_RST_TOPD   = 1'b1;

  // ----------------------------------------------------------------
  // Instruction encodings
  // ----------------------------------------------------------------
  localparam logic [6:0]  CIE_OPC_FILE_HI  = 7'h03;   // 00 0001 1 then 7-bit address
  localparam logic [6:0]  CIE_OPC_ACC_HI   = 7'h02;   // 00 0001 0 then don't-care
  localparam logic [13:0] CIE_OPC_WDOG     = 14'h0064; // 00 0000 0110 0100
  localparam int          CIE_FILE_ADDR_W  = 7;
  localparam int          CIE_Q_PER_CYCLE  = 4;       // Clocks per instruction cycle

  // ----------------------------------------------------------------
  // Quarter phases and operation kinds
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CIE_IDLE = 5'h01,
    CIE_Q1   = 5'h02,
    CIE_Q2   = 5'h04,
    CIE_Q3   = 5'h08,
    CIE_Q4   = 5'h10
  } cie_phase_t;

  typedef enum logic [3:0] {
    CIE_K_NONE = 4'h1,
    CIE_K_FILE = 4'h2,
    CIE_K_ACC  = 4'h4,
    CIE_K_WDOG = 4'h8
  } cie_kind_t;

endpackage : cie_pkg

// File: tb_clear_instruction_execute.sv
// Self-checking bench for the clear-instruction execute block
`timescale 1ns/1ps
module tb_clear_instruction_execute;
  import cie_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clock;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_w;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        watchdog_clear;
  logic        prescaler_clear;
  logic        zero_flag;
  logic        timeout_flag;
  logic        powerdown_flag;
  logic        busy;
  int          error_cnt;
  int          tests_run;
  int          cycles;
  int          wd_cnt;
  int          seed;
  logic        exp_z;
  logic        exp_to;
  logic        exp_pd;
  logic [31:0] q;

  cie_clear_exec #(.FILE_DEPTH(128), .WDCNT_W(16)) DUT (
    .clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat_w), .dat_o(dat_o), .ack_o(ack_o),
    .watchdog_clear(watchdog_clear), .prescaler_clear(prescaler_clear),
    .zero_flag(zero_flag), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .busy(busy)
  );

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  always #12.5 clock = ~clock;

  // Cut a hang short; the tests need about a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("mismatch at %0t: run did not finish", $time);
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Expectation, compare and bus tasks
  // ----------------------------------------------------------------
  // Kind of an opcode: 0 other, 1 clear file, 2 clear accumulator, 3 clear watchdog
  function automatic int kind_of(input logic [13:0] op);
    if (op == 14'h0064) return 3;
    if (op[13:7] == 7'h03) return 1;
    if (op[13:7] == 7'h02) return 2;
    return 0;
  endfunction : kind_of

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk_word

  // One classic cycle; returns at the edge where ack was sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clock);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    sel   <= 4'hF;
    adr   <= a;
    dat_w <= d;
    do @(posedge clock); while (ack_o !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  // Load one file register through the index and data windows
  task automatic setf(input logic [6:0] f, input logic [7:0] d);
    wb(1'b1, CIE_ADDR_FSEL, {25'h0, f}, q);
    wb(1'b1, CIE_ADDR_FDATA, {24'h0, d}, q);
  endtask : setf

  task automatic getf(input logic [6:0] f, input logic [7:0] d, input string msg);
    wb(1'b1, CIE_ADDR_FSEL, {25'h0, f}, q);
    wb(1'b0, CIE_ADDR_FDATA, 32'h0, q);
    chk_word(q, {24'h0, d}, msg);
  endtask : getf

  // Set the three flags from software and mirror them
  task automatic set_st(input logic [2:0] st);
    wb(1'b1, CIE_ADDR_STATUS, {29'h0, st}, q);
    {exp_pd, exp_to, exp_z} = st;
  endtask : set_st

  // Issue one opcode and follow its four phases at the ports
  task automatic exec(input logic [13:0] op);
    int k;
    k = kind_of(op);
    wb(1'b1, CIE_ADDR_INSTR, {18'h0, op}, q);
    #1;
    chk_bit(busy, 1'b1, "busy at first phase");
    repeat (3) begin
      @(posedge clock);
      #1;
      chk_bit(busy, 1'b1, "busy in mid phases");
      chk_bit(watchdog_clear, 1'b0, "early watchdog clear");
    end
    @(posedge clock);
    #1;
    if (k == 1 || k == 2) exp_z = 1'b1;
    if (k == 3) begin
      exp_to = 1'b1;
      exp_pd = 1'b1;
      wd_cnt++;
    end
    chk_bit(busy, 1'b0, "busy after one cycle");
    chk_bit(watchdog_clear, k == 3, "watchdog clear pulse");
    chk_bit(prescaler_clear, k == 3, "prescaler clear pulse");
    chk_bit(zero_flag, exp_z, "zero flag");
    chk_bit(timeout_flag, exp_to, "timeout flag");
    chk_bit(powerdown_flag, exp_pd, "powerdown flag");
    @(posedge clock);
    #1;
    chk_bit(watchdog_clear, 1'b0, "watchdog pulse ends");
  endtask : exec

  task automatic test_done();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin : main_seq
    logic [13:0] op;
    logic [6:0]  f;
    logic [7:0]  d;
    logic [7:0]  a;
    clock = 1'b0;
    rst   = 1'b1;
    {cyc, stb, we, adr, dat_w} = '0;
    sel = 4'hF;
    {error_cnt, tests_run, cycles, wd_cnt} = '0;
    seed = $urandom(40);
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    // Top and neighbouring file registers, then address zero
    set_st(3'h0);
    setf(7'h7E, 8'hA5);
    setf(7'h7F, 8'h5A);
    exec(14'h01FF);
    getf(7'h7F, 8'h00, "file 127 cleared");
    getf(7'h7E, 8'hA5, "file 126 untouched");
    setf(7'h00, 8'h3C);
    exec(14'h0180);
    getf(7'h00, 8'h00, "file 0 cleared");
    // Near misses of the watchdog pattern do nothing
    set_st(3'h0);
    wb(1'b1, CIE_ADDR_ACCUM, 32'h33, q);
    exec(14'h0065);
    exec(14'h0044);
    exec(14'h0080);
    wb(1'b0, CIE_ADDR_ACCUM, 32'h0, q);
    chk_word(q, 32'h33, "accumulator kept");
    // Accumulator clear with both extremes of the free bits
    wb(1'b1, CIE_ADDR_ACCUM, 32'h5A, q);
    exec(14'h017F);
    wb(1'b0, CIE_ADDR_ACCUM, 32'h0, q);
    chk_word(q, 32'h0, "accumulator cleared");
    wb(1'b1, CIE_ADDR_ACCUM, 32'hA5, q);
    exec(14'h0100);
    wb(1'b0, CIE_ADDR_ACCUM, 32'h0, q);
    chk_word(q, 32'h0, "accumulator cleared, free bits low");
    exec(14'h0064);
    // Random mix of opcodes and prior state
    repeat (30) begin
      f = 7'($urandom_range(127));
      d = 8'($urandom_range(254) + 1);
      a = 8'($urandom_range(254) + 1);
      set_st(3'($urandom_range(7)));
      setf(f, d);
      wb(1'b1, CIE_ADDR_ACCUM, {24'h0, a}, q);
      case ($urandom_range(3))
        0: op = {7'h03, f};
        1: op = {7'h02, 7'($urandom_range(127))};
        2: op = 14'h0064;
        default: op = 14'($urandom_range(16383));
      endcase
      exec(op);
      wb(1'b0, CIE_ADDR_FDATA, 32'h0, q);
      chk_word(q, (kind_of(op) == 1 && op[6:0] == f) ? 32'h0 : {24'h0, d}, "file");
      wb(1'b0, CIE_ADDR_ACCUM, 32'h0, q);
      chk_word(q, (kind_of(op) == 2) ? 32'h0 : {24'h0, a}, "accumulator");
      wb(1'b0, CIE_ADDR_STATUS, 32'h0, q);
      chk_word(q & 32'h1F, {27'h0, kind_of(op) == 0, 1'b0, exp_pd, exp_to, exp_z},
               "status");
    end
    wb(1'b0, CIE_ADDR_WDCNT, 32'h0, q);
    chk_word(q, {16'h0, 16'(wd_cnt)}, "watchdog clear count");
    test_done();
  end

endmodule : tb_clear_instruction_execute
